// >>> hdl/adc_seq_defines.svh
// Constants of the sequencer converter control block: timing, codes,
// register offsets and field positions.
// Assumes a 100 MHz peripheral clock; included by the clock generator and the control block.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Clock rates and converter clock dividers, in peripheral cycles per half converter cycle
`define PCLK_MHZ 100
`define ASYNC_CLK_MHZ 14
`define ASYNC_HALF_DIV ((`PCLK_MHZ + 2 * `ASYNC_CLK_MHZ - 1) / (2 * `ASYNC_CLK_MHZ))
`define DIV2_HALF_DIV 1
`define DIV4_HALF_DIV 2

// Clock source codes
`define CKSEL_ASYNC 2'h0
`define CKSEL_DIV2 2'h1
`define CKSEL_DIV4 2'h2

// Resolution codes and result shifts
`define RES_12 2'h0
`define RES_10 2'h1
`define RES_8 2'h2
`define RES_6 2'h3
`define SHIFT_12 4'h0
`define SHIFT_10 4'h2
`define SHIFT_8 4'h4
`define SHIFT_6 4'h6

// Sampling lengths in half converter cycles (1.5 .. 239.5 cycles)
`define SMP_HT_0 10'h003
`define SMP_HT_1 10'h00F
`define SMP_HT_2 10'h01B
`define SMP_HT_3 10'h039
`define SMP_HT_4 10'h053
`define SMP_HT_5 10'h06F
`define SMP_HT_6 10'h08F
`define SMP_HT_7 10'h1DF

// Conversion lengths in half converter cycles (12.5, 11.5, 9.5, 7.5)
`define CNV_HT_12 10'h019
`define CNV_HT_10 10'h017
`define CNV_HT_8 10'h013
`define CNV_HT_6 10'h00F

// Register byte offsets
`define OFS_CONFIG_ONE 8'h00
`define OFS_CONFIG_TWO 8'h04
`define OFS_SAMPLE_TIME 8'h08
`define OFS_CHANNEL_MASK 8'h0C
`define OFS_IRQ_ENABLE 8'h10
`define OFS_STATUS 8'h14
`define OFS_RESULT 8'h18
`define OFS_LATENCY 8'h1C

// Field positions
`define CFG1_RES_MSB 1
`define CFG1_RES_LSB 0
`define CFG1_SCAN_DIRECTION 2
`define CFG1_CONTINUOUS_ENABLE 3
`define CFG1_DISC 4
`define CFG1_ALIGN 5
`define CFG1_W 6
`define STAT_EOC 0
`define STAT_EOS 1
`define IRQ_EOC 0
`define IRQ_EOS 1
`define LAT_TRIGGER_INPUT_MSB 3
`define LAT_WR_LSB 8
`define LAT_WR_MSB 15

// Reset values and bus answers
`define CFG1_RESET 6'h00
`define CKSEL_RESET 2'h0
`define SMP_RESET 3'h0
`define MASK_RESET 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hdl/adc_seq_pkg.sv
// Types shared by the sequencer converter control block.
// Assumes nothing beyond the defines header.
package adc_seq_pkg;

   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_SYNC    = 6'h02,
      ST_LATENCY = 6'h04,
      ST_SAMPLE  = 6'h08,
      ST_CONVERT = 6'h10,
      ST_WRITE   = 6'h20
   } seq_state_t;

   // Sixteen 12-bit sampled channel values
   typedef logic [15:0][11:0] sample_array_t;

   // Sixteen 16-bit per-channel results
   typedef logic [15:0][15:0] result_array_t;

endpackage

// >>> hdl/adc_clock_gen.sv
// Converter clock enable generator: half-cycle and rising-edge pulses.
// Assumes one peripheral clock; the converter clock exists only as enables.
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module adc_clock_gen (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Source choice
   input wire logic [1:0] clock_source_select,
   // Enables
   output logic half_tick,
   output logic rise_tick
);

   typedef struct packed {
      logic [2:0] cnt;
      logic phase;
      logic half;
      logic rise;
   } ckgen_state_t;

   ckgen_state_t s;
   ckgen_state_t next_s;

   // Half-period length in peripheral cycles for a source code
   function automatic logic [2:0] half_div(input logic [1:0] sel);
      case (sel)
         `CKSEL_ASYNC: half_div = 3'(`ASYNC_HALF_DIV);
         `CKSEL_DIV2: half_div = 3'(`DIV2_HALF_DIV);
         default: half_div = 3'(`DIV4_HALF_DIV);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // divider select
   // Counts out half periods; rising edge on every second half tick
   always_comb begin
      next_s = s;
      next_s.half = 1'b0;
      next_s.rise = 1'b0;
      if (s.cnt + 3'h1 >= half_div(clock_source_select)) begin
         next_s.cnt = 3'h0;
         next_s.half = 1'b1;
         next_s.rise = ~s.phase;
         next_s.phase = ~s.phase;
      end else begin
         next_s.cnt = s.cnt + 3'h1;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign half_tick = s.half;
   assign rise_tick = s.rise;

endmodule

// >>> hdl/adc_channel_pick.sv
// Channel order finder: first member and successor in scan order.
// Assumes a 16-bit channel mask and a current channel index.
`timescale 1ns/1ns

module adc_channel_pick (
   // Sequence description
   input wire logic [15:0] channel_select_mask,
   input wire logic scan_direction,
   input wire logic [3:0] current_channel,
   // Answers
   output logic [3:0] first_channel,
   output logic [3:0] next_channel,
   output logic has_next
);

   // First set bit: lowest when scanning up, highest when scanning down
   function automatic logic [3:0] find_first(input logic [15:0] m, input logic dn);
      find_first = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (m[dn ? i : 15 - i]) begin
            find_first = 4'(dn ? i : 15 - i);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // scan order
   // Successor strictly beyond the current channel in scan direction
   always_comb begin
      next_channel = current_channel;
      has_next = 1'b0;
      for (int j = 0; j < 16; j++) begin
         if (scan_direction) begin
            if (channel_select_mask[j] && 4'(j) < current_channel) begin
               next_channel = 4'(j);
               has_next = 1'b1;
            end
         end else begin
            if (channel_select_mask[15 - j] && 4'(15 - j) > current_channel) begin
               next_channel = 4'(15 - j);
               has_next = 1'b1;
            end
         end
      end
   end

   assign first_channel = find_first(channel_select_mask, scan_direction);

endmodule

// >>> hdl/adc_sequencer_control.sv
// Sequencer converter control: registers over AXI4-Lite, trigger
// handling, channel sequencing, timing, results and event pulses.
// Assumes synchronous trigger and sampled channel values on aclk.
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module adc_sequencer_control (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Trigger and channels
   input wire logic trigger_input,
   input wire adc_seq_pkg::sample_array_t analog_channel,
   // Results and events
   output adc_seq_pkg::result_array_t channel_result,
   output logic [15:0] conversion_result,
   output logic conversion_done_pulse,
   output logic sequence_done_pulse,
   output logic conversion_active
);
   import adc_seq_pkg::*;

   typedef struct packed {
      seq_state_t state;
      logic [9:0] cnt;
      logic [3:0] chan;
      logic [3:0] pos;
      logic pos_ok;
      logic trigger_input_prev;
      logic [11:0] hold;
      logic [`CFG1_W-1:0] cfg1;
      logic [1:0] cksel;
      logic [2:0] sample_time_code;
      logic [15:0] mask;
      logic [1:0] irq_en;
      logic eoc_flag;
      logic eos_flag;
      logic [3:0] trigger_input_lat;
      logic [7:0] wr_lat;
      logic [15:0] result;
      result_array_t res_all;
      logic eoc_pulse;
      logic eos_pulse;
      logic active;
      logic aw_ok;
      logic w_ok;
      logic [7:0] aw_q;
      logic [31:0] w_q;
      logic [3:0] strb_q;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } seq_ctrl_state_t;

   seq_ctrl_state_t s;
   seq_ctrl_state_t next_s;
   logic half_tick;
   logic rise_tick;
   logic [3:0] first_ch;
   logic [3:0] next_ch;
   logic has_next;
   logic trigger_input_edge;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] wsel;
   logic do_write;
   logic [3:0] start_ch;

   // Byte-lane merge of a write into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = st[b] ? d[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   // Sampling length in half converter cycles
   function automatic logic [9:0] smp_ht(input logic [2:0] code);
      case (code)
         3'h0: smp_ht = `SMP_HT_0;
         3'h1: smp_ht = `SMP_HT_1;
         3'h2: smp_ht = `SMP_HT_2;
         3'h3: smp_ht = `SMP_HT_3;
         3'h4: smp_ht = `SMP_HT_4;
         3'h5: smp_ht = `SMP_HT_5;
         3'h6: smp_ht = `SMP_HT_6;
         default: smp_ht = `SMP_HT_7;
      endcase
   endfunction

   // Conversion length in half converter cycles
   function automatic logic [9:0] cnv_ht(input logic [1:0] res);
      case (res)
         `RES_12: cnv_ht = `CNV_HT_12;
         `RES_10: cnv_ht = `CNV_HT_10;
         `RES_8: cnv_ht = `CNV_HT_8;
         default: cnv_ht = `CNV_HT_6;
      endcase
   endfunction

   // Right shift that trims a 12-bit sample to the resolution
   function automatic logic [3:0] res_shift(input logic [1:0] res);
      case (res)
         `RES_12: res_shift = `SHIFT_12;
         `RES_10: res_shift = `SHIFT_10;
         `RES_8: res_shift = `SHIFT_8;
         default: res_shift = `SHIFT_6;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Converter clock enables and channel order

   adc_clock_gen u_clock_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .clock_source_select(s.cksel),
      .half_tick(half_tick),
      .rise_tick(rise_tick)
   );

   adc_channel_pick u_channel_pick (
      .channel_select_mask(s.mask),
      .scan_direction(s.cfg1[`CFG1_SCAN_DIRECTION]),
      .current_channel(s.chan),
      .first_channel(first_ch),
      .next_channel(next_ch),
      .has_next(has_next)
   );

   ////////////////////////////////////////////////////////////////////////
   // Write path, address and data in either order
   assign wa = s.aw_ok ? s.aw_q : awaddr;
   assign wd = s.w_ok ? s.w_q : wdata;
   assign wsel = s.w_ok ? s.strb_q : wstrb;
   assign do_write = (s.aw_ok || (awvalid && s.awready)) && (s.w_ok || (wvalid && s.wready))
                     && !s.bvalid;
   assign trigger_input_edge = trigger_input && !s.trigger_input_prev;
   assign start_ch = (s.cfg1[`CFG1_DISC] && s.pos_ok && s.mask[s.pos]) ? s.pos : first_ch;

   // Next state: bus slave first, then the sequencer
   always_comb begin
      next_s = s;
      next_s.eoc_pulse = 1'b0;
      next_s.eos_pulse = 1'b0;
      next_s.trigger_input_prev = trigger_input;
      // Write channel capture
      if (awvalid && s.awready && !do_write) begin
         next_s.aw_ok = 1'b1;
         next_s.aw_q = awaddr;
      end
      if (wvalid && s.wready && !do_write) begin
         next_s.w_ok = 1'b1;
         next_s.w_q = wdata;
         next_s.strb_q = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (do_write) begin
         next_s.aw_ok = 1'b0;
         next_s.w_ok = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `RESP_OKAY;
         case (wa)
            `OFS_CONFIG_ONE: next_s.cfg1 = `CFG1_W'(merge(32'(s.cfg1), wd, wsel));
            `OFS_CONFIG_TWO: next_s.cksel = 2'(merge(32'(s.cksel), wd, wsel));
            `OFS_SAMPLE_TIME: next_s.sample_time_code = 3'(merge(32'(s.sample_time_code), wd, wsel));
            `OFS_CHANNEL_MASK: next_s.mask = 16'(merge(32'(s.mask), wd, wsel));
            `OFS_IRQ_ENABLE: next_s.irq_en = 2'(merge(32'(s.irq_en), wd, wsel));
            `OFS_STATUS: begin
               if (wsel[0] && wd[`STAT_EOC]) next_s.eoc_flag = 1'b0;
               if (wsel[0] && wd[`STAT_EOS]) next_s.eos_flag = 1'b0;
            end
            `OFS_RESULT: next_s.bresp = `RESP_OKAY;
            `OFS_LATENCY: begin
               next_s.trigger_input_lat = 4'(merge(32'({s.wr_lat, 4'h0, s.trigger_input_lat}), wd, wsel));
               next_s.wr_lat = 8'(merge(32'({s.wr_lat, 4'h0, s.trigger_input_lat}), wd, wsel)
                  >> `LAT_WR_LSB);
            end
            default: next_s.bresp = `RESP_SLVERR;
         endcase
      end
      // Read channel
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `RESP_OKAY;
         case (araddr)
            `OFS_CONFIG_ONE: next_s.rdata = 32'(s.cfg1);
            `OFS_CONFIG_TWO: next_s.rdata = 32'(s.cksel);
            `OFS_SAMPLE_TIME: next_s.rdata = 32'(s.sample_time_code);
            `OFS_CHANNEL_MASK: next_s.rdata = 32'(s.mask);
            `OFS_IRQ_ENABLE: next_s.rdata = 32'(s.irq_en);
            `OFS_STATUS: next_s.rdata = 32'({s.active, s.eos_flag, s.eoc_flag});
            `OFS_RESULT: next_s.rdata = 32'(s.result);
            `OFS_LATENCY: next_s.rdata = 32'({s.wr_lat, 4'h0, s.trigger_input_lat});
            default: begin
               next_s.rdata = 32'h0000_0000;
               next_s.rresp = `RESP_SLVERR;
            end
         endcase
      end
      // Sequencer
      unique case (s.state)
         ST_IDLE: begin
            if (trigger_input_edge && s.mask != 16'h0000) next_s.state = ST_SYNC;
         end
         ST_SYNC: begin
            if (rise_tick) begin
               next_s.chan = start_ch;
               next_s.cnt = {5'h00, s.trigger_input_lat, 1'b0};
               next_s.state = ST_LATENCY;
            end
         end
         ST_LATENCY: begin
            if (s.cnt == 10'h000) begin
               next_s.cnt = smp_ht(s.sample_time_code);
               next_s.state = ST_SAMPLE;
            end else if (half_tick) begin
               next_s.cnt = s.cnt - 10'h001;
            end
         end
         ST_SAMPLE: begin
            if (half_tick) begin
               if (s.cnt == 10'h001) begin
                  next_s.hold = analog_channel[s.chan];
                  next_s.cnt = cnv_ht(s.cfg1[`CFG1_RES_MSB:`CFG1_RES_LSB]);
                  next_s.state = ST_CONVERT;
               end else begin
                  next_s.cnt = s.cnt - 10'h001;
               end
            end
         end
         ST_CONVERT: begin
            if (half_tick) begin
               if (s.cnt == 10'h001) begin
                  next_s.cnt = {1'b0, s.wr_lat, 1'b0};
                  next_s.state = ST_WRITE;
               end else begin
                  next_s.cnt = s.cnt - 10'h001;
               end
            end
         end
         ST_WRITE: begin
            if (s.cnt == 10'h000) begin
               next_s.result = 16'(s.hold) >> res_shift(s.cfg1[`CFG1_RES_MSB:`CFG1_RES_LSB]);
               next_s.res_all[s.chan] = next_s.result;
               next_s.eoc_flag = 1'b1;
               next_s.eoc_pulse = s.irq_en[`IRQ_EOC];
               if (!has_next) begin
                  next_s.eos_flag = 1'b1;
                  next_s.eos_pulse = s.irq_en[`IRQ_EOS];
               end
               if (s.cfg1[`CFG1_DISC]) begin
                  next_s.pos = next_ch;
                  next_s.pos_ok = has_next;
                  next_s.state = ST_IDLE;
               end else if (has_next) begin
                  next_s.chan = next_ch;
                  next_s.cnt = smp_ht(s.sample_time_code);
                  next_s.state = ST_SAMPLE;
               end else begin
                  next_s.state = ST_IDLE;
               end
            end else if (half_tick) begin
               next_s.cnt = s.cnt - 10'h001;
            end
         end
      endcase
      next_s.active = next_s.state != ST_IDLE;
      next_s.awready = !next_s.aw_ok && !next_s.bvalid;
      next_s.wready = !next_s.w_ok && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.state <= ST_IDLE;
         s.cfg1 <= `CFG1_RESET;
         s.cksel <= `CKSEL_RESET;
         s.sample_time_code <= `SMP_RESET;
         s.mask <= `MASK_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign channel_result = s.res_all;
   assign conversion_result = s.result;
   assign conversion_done_pulse = s.eoc_pulse;
   assign sequence_done_pulse = s.eos_pulse;
   assign conversion_active = s.active;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_eoc_gated: assert property (conversion_done_pulse |-> $past(s.irq_en[`IRQ_EOC]))
      else $error("end-of-conversion pulse while disabled");
   a_eoc_single: assert property (conversion_done_pulse |=> !conversion_done_pulse)
      else $error("end-of-conversion pulse longer than one cycle");
   a_eos_follows_eoc: assert property (sequence_done_pulse && $past(s.irq_en[`IRQ_EOC])
      |-> conversion_done_pulse)
      else $error("end-of-sequence without end-of-conversion");
   a_busy_drops: assert property (s.state == ST_SAMPLE && trigger_input_edge
      |=> s.state inside {ST_SAMPLE, ST_CONVERT})
      else $error("trigger disturbed a running sample");
   a_sample_load: assert property ($rose(s.state == ST_SAMPLE) && $stable(s.sample_time_code)
      |-> s.cnt == smp_ht(s.sample_time_code))
      else $error("sampling length not loaded");
   a_convert_load: assert property ($rose(s.state == ST_CONVERT) && $stable(s.cfg1)
      |-> s.cnt == cnv_ht(s.cfg1[`CFG1_RES_MSB:`CFG1_RES_LSB]))
      else $error("conversion length not loaded");
   a_six_bit_range: assert property ($past(s.state == ST_WRITE && s.cnt == 10'h000
      && s.cfg1[`CFG1_RES_MSB:`CFG1_RES_LSB] == `RES_6) |-> conversion_result[15:6] == 10'h000)
      else $error("6-bit result too wide");
   a_active_level: assert property (conversion_active == (s.state != ST_IDLE))
      else $error("active output disagrees with sequencer");
   a_active_start: assert property (s.state == ST_IDLE && trigger_input_edge
      && s.mask != 16'h0000 |=> conversion_active)
      else $error("accepted trigger did not start a conversion");
   a_mask_member: assert property (s.state == ST_SAMPLE && $stable(s.mask) |-> s.mask[s.chan])
      else $error("sampling a channel outside the mask");
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");

endmodule

// >>> testbench/adc_source_model.sv
// Far side model: trigger source and sixteen analog channel levels.
// Assumes the bench raises fire for one aclk cycle per trigger wanted.
`timescale 1ns/1ns

module adc_source_model (
   // Clock and request
   input wire logic aclk,
   input wire logic fire,
   // Far side outputs
   output logic trigger_input,
   output adc_seq_pkg::sample_array_t analog_channel
);
   import adc_seq_pkg::*;
   logic [1:0] hold = 2'h0;
   // Fixed levels, channel number in the top nibble
   always_comb begin
      for (int n = 0; n < 16; n++) begin
         analog_channel[n] = {4'(n), 8'hA5};
      end
   end
   // Trigger held high two cycles per request, low otherwise
   always @(posedge aclk) begin
      hold <= fire ? 2'h2 : ((hold == 2'h0) ? 2'h0 : hold - 2'h1);
   end
   assign trigger_input = (hold != 2'h0);
endmodule

// >>> testbench/adc_sequencer_control_test.sv
// Self-checking bench of the sequencer converter control block.
// Assumes the design files and the far side model are compiled first.
`timescale 1ns/1ns

module adc_sequencer_control_test;
   import adc_seq_pkg::*;
   logic aclk = 0, aresetn = 0, fire = 0, trigger_input;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rr, br;
   logic [15:0] conversion_result;
   logic conversion_done_pulse, sequence_done_pulse, conversion_active;
   sample_array_t analog_channel;
   result_array_t channel_result;
   int n_errors = 0, num_checks = 0, cycles = 0, ne, ns, na;
   logic [1:0] row_res [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [2:0] row_smp [4] = '{3'h1, 3'h0, 3'h7, 3'h2};
   // Nominal active cycles: (latency 1 + write 2 cycles, sample, conversion) in
   // half cycles, times aclk per half cycle (4 async, 1 by two, 2 by four)
   int row_len [4] = '{184, 32, 1008, 96};
   logic [3:0] row_ch [4] = '{4'h5, 4'h0, 4'hF, 4'h9};
   logic [15:0] row_exp [4] = '{16'h05A5, 16'h0029, 16'h00FA, 16'h0026};
   logic [15:0] seq_exp [3] = '{16'h00A5, 16'h04A5, 16'h08A5};

   adc_sequencer_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .trigger_input(trigger_input), .analog_channel(analog_channel),
      .channel_result(channel_result), .conversion_result(conversion_result),
      .conversion_done_pulse(conversion_done_pulse), .sequence_done_pulse(sequence_done_pulse),
      .conversion_active(conversion_active));
   adc_source_model far (.aclk(aclk), .fire(fire), .trigger_input(trigger_input),
      .analog_channel(analog_channel));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, bus cycles and trigger runs
   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 0;
         if (wready === 1'b1) wvalid <= 0;
      end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
      while (bvalid !== 1'b1) @(posedge aclk);
      br = bresp;
      bready <= 0;
      @(posedge aclk);
   endtask
   task axr(input logic [7:0] a);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rd = rdata; rr = rresp; rready <= 0;
      @(posedge aclk);
   endtask
   // One trigger; extra fires a second one while busy; counts the pulses
   task run(input logic extra);
      int t;
      ne = 0; ns = 0; t = 0; fire <= 1;
      @(posedge aclk);
      fire <= 0;
      while (conversion_active !== 1'b1 && t < 100) begin @(posedge aclk); t++; end
      if (extra) begin repeat (4) @(posedge aclk); fire <= 1; @(posedge aclk); fire <= 0; end
      for (t = 0; t < 5000 && (conversion_active === 1'b1 || t < 3); t++) begin
         @(posedge aclk);
         ne += (conversion_done_pulse === 1'b1);
         ns += (sequence_done_pulse === 1'b1);
      end
      na = t;
      repeat (3) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      axr(8'h00); check("config_one reset", 32'h0, rd);
      axr(8'h0C); check("mask reset", 32'h0, rd);
      axr(8'h40); check("unmapped resp", 2'h2, rr);
      check("unmapped data", 32'h0, rd);
      axw(8'h40, 32'h0);
      check("unmapped bresp", 2'h2, br);
      $display("test registers done");
      axw(8'h10, 32'h3);
      axw(8'h1C, 32'h0201);
      // Each row: resolution, clock source, one channel, expected result
      for (int i = 0; i < 4; i++) begin
         axw(8'h00, {30'h0, row_res[i]});
         axw(8'h04, {30'h0, row_res[i]});
         axw(8'h0C, 32'h1 << row_ch[i]);
         axw(8'h08, {29'h0, row_smp[i]});
         run(0);
         check("active cycles", 1, na >= row_len[i] && na <= row_len[i] + 12);
         check("conversion_result", row_exp[i], conversion_result);
         check("channel_result", row_exp[i], channel_result[row_ch[i]]);
      end
      $display("test resolutions done");
      axw(8'h00, 32'h0);
      axw(8'h04, 32'h1);
      axw(8'h0C, 32'h0111);
      run(1);
      check("eoc count", 3, ne);
      check("eos count", 1, ns);
      check("last upward", 16'h08A5, conversion_result);
      check("channel four", 16'h04A5, channel_result[4]);
      axr(8'h14);
      check("status flags", 32'h3, rd);
      axw(8'h14, 32'h3);
      axr(8'h14);
      check("status cleared", 32'h0, rd);
      axw(8'h00, 32'h4);
      run(0);
      check("last downward", 16'h00A5, conversion_result);
      $display("test sequences done");
      axw(8'h00, 32'h10);
      for (int k = 0; k < 6; k++) begin
         run(0);
         check("disc eoc", 1, ne);
         check("disc eos", (k % 3 == 2), ns);
         check("disc result", seq_exp[k % 3], conversion_result);
      end
      $display("test discontinuous done");
      axw(8'h10, 32'h0);
      axw(8'h00, 32'h0);
      run(0);
      check("masked eoc", 0, ne);
      check("masked eos", 0, ns);
      check("active idle", 1'b0, conversion_active);
      $display("test masking done");
      // Reset in the middle of a conversion
      fire <= 1;
      @(posedge aclk);
      fire <= 0;
      repeat (6) @(posedge aclk);
      check("active before reset", 1'b1, conversion_active);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      check("active in reset", 1'b0, conversion_active);
      repeat (2) @(posedge aclk);
      axr(8'h0C);
      check("mask after reset", 32'h0, rd);
      $display("test reset done");
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counts and verdict
   task close_out();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
endmodule
